// ===== src/rmsg_regs.svh
// Constants for the radio module status and mode gate
//
// Overview of operation
// RL1 - Power-up: status low, self-check, load mode
// RL2 - After init: status high, use pin mode
// RL3 - Host waits for status rising edge
// RL4 - Status low while transmit buffer holds data
// RL5 - Under 1000 bytes streamed never overflow
// RL6 - Auto sub-packets; idle timeout before sending
// RL7 - Status may rise during final sub-packet
// RL8 - Status low while serial output pending
// RL9 - Status low on any busy condition
// RL10 - Pins ignored while low; switch within 1ms
// RL11 - New mode works after 2ms high
// RL12 - Leaving sleep or reset reloads parameters
// RL13 - Own address all-ones transmits broadcast
// RL14 - Own address all-ones receives everything
// RL15 - Host always drives both mode pins
// RL16 - Pins 00 normal, 01 wake, 10 config, 11 sleep
// RL17 - Pending data finishes before requested mode
// RL18 - Mode pins pass two synchroniser stages
`ifndef RMSG_REGS_SVH
`define RMSG_REGS_SVH
// ---------------------------------------------------------------
// Register word indices
// ---------------------------------------------------------------
`define RMSG_ADDR_W       3
`define RMSG_IDX_CTRL     3'h0
`define RMSG_IDX_STATUS   3'h1
`define RMSG_IDX_OWNADDR  3'h2
`define RMSG_IDX_TIMEOUT  3'h3
`define RMSG_IDX_SUBLEN   3'h4
`define RMSG_IDX_IRQSTAT  3'h5
`define RMSG_IDX_IRQMASK  3'h6
// ---------------------------------------------------------------
// Fields, reset values, sizes
// ---------------------------------------------------------------
`define RMSG_CTRL_RELOAD  0
`define RMSG_IRQ_W        3
`define RMSG_IRQ_READY    0
`define RMSG_IRQ_MODE     1
`define RMSG_IRQ_OVF      2
`define RMSG_BCAST_ADDR   16'hffff
`define RMSG_RST_OWNADDR  16'h0000
`define RMSG_RST_TIMEOUT  16'h0100
`define RMSG_RST_SUBLEN   8'hf0
`define RMSG_BUF_DEPTH    1000
`define RMSG_CNT_W        10
`define RMSG_MODE_SLEEP   2'h3
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define RMSG_CLK_NS       5
`define RMSG_HOLD_NS      2000000
`define RMSG_INIT_CYCLES  64
`define RMSG_HOLD_W       19
`endif

// ===== src/rmsg_pkg.sv
// Types for the radio module status and mode gate
`include "rmsg_regs.svh"
package rmsg_pkg;
  typedef enum logic [1:0] {ST_INIT, ST_RUN} rmsg_state_e;
  typedef enum logic [1:0] {MD_NORMAL, MD_WAKE, MD_CONFIG, MD_SLEEP} rmsg_mode_e;  // see RL16
  typedef struct packed {
    rmsg_state_e                  state;
    logic [1:0]                   sync1;
    logic [1:0]                   sync2;
    rmsg_mode_e                   selected;
    rmsg_mode_e                   working;
    logic [7:0]                   init_cnt;
    logic [`RMSG_HOLD_W-1:0]      hold;
    logic [`RMSG_CNT_W-1:0]       count;
    logic [`RMSG_CNT_W-1:0]       wr_ptr;
    logic [`RMSG_CNT_W-1:0]       rd_ptr;
    logic [15:0]                  idle;
    logic                         drain;
    logic [7:0]                   sub_cnt;
    logic [15:0]                  own_addr;
    logic [15:0]                  timeout;
    logic [7:0]                   sublen;
    logic [`RMSG_IRQ_W-1:0]       irq_stat;
    logic [`RMSG_IRQ_W-1:0]       irq_mask;
    logic                         wait_req;
    logic [31:0]                  rdata;
    logic                         aux;
    logic                         irq;
    logic                         host_ready;
    logic                         radio_valid;
    logic [7:0]                   radio_byte;
    logic                         radio_last;
    logic                         broadcast;
    logic                         rx_accept;
  } rmsg_state_s;
endpackage

// ===== src/rmsg_top.sv
// Status output, mode gate, transmit buffer and register slave
`timescale 1ns/1ps
`include "rmsg_regs.svh"
module rmsg_top
  import rmsg_pkg::*;
#(
  parameter int DEPTH       = `RMSG_BUF_DEPTH,
  parameter int HOLD_CYCLES = `RMSG_HOLD_NS / `RMSG_CLK_NS,
  parameter int INIT_CYCLES = `RMSG_INIT_CYCLES
) (
  // Clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     reset_i,
  // Module pins
  input  wire logic                     module_reset_input_n_i,
  input  wire logic                     mode_select_low_i,
  input  wire logic                     mode_select_high_i,
  output logic                          aux_o,
  // Host bytes from the serial receiver
  input  wire logic                     host_byte_valid_i,
  input  wire logic [7:0]               host_byte_i,
  output logic                          host_ready_o,
  // Radio chip side
  output logic                          radio_valid_o,
  output logic [7:0]                    radio_byte_o,
  output logic                          radio_last_o,
  input  wire logic                     radio_ready_i,
  input  wire logic                     rx_frame_valid_i,
  input  wire logic [15:0]              rx_dest_addr_i,
  input  wire logic                     rx_serial_busy_i,
  output logic                          rx_accept_o,
  output logic                          tx_broadcast_o,
  output logic [1:0]                    working_mode_o,
  // Avalon-MM slave
  input  wire logic [`RMSG_ADDR_W-1:0]  avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [31:0]              avs_writedata_i,
  input  wire logic [3:0]               avs_byteenable_i,
  output logic [31:0]                   avs_readdata_o,
  output logic                          avs_waitrequest_o,
  output logic                          irq_o
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Lanes left off keep the old field value
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [`RMSG_CNT_W-1:0] ptr_inc(input logic [`RMSG_CNT_W-1:0] p);
    return (p == `RMSG_CNT_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  localparam logic [`RMSG_HOLD_W-1:0] HOLD_MAX = `RMSG_HOLD_W'(HOLD_CYCLES);
  localparam logic [`RMSG_CNT_W-1:0]  CNT_MAX  = `RMSG_CNT_W'(DEPTH);

  rmsg_state_s s;
  rmsg_state_s n;
  logic [7:0]  mem [DEPTH];
  logic        push;
  logic        pop;
  logic        acc;
  logic        wr_acc;
  logic [31:0] wmerged;
  logic [31:0] rd_mux;
  logic [`RMSG_IRQ_W-1:0] ev;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    n       = s;
    push    = 1'b0;
    pop     = 1'b0;
    ev      = '0;
    rd_mux  = 32'h0000_0000;
    wmerged = 32'h0000_0000;
    acc     = (avs_read_i || avs_write_i) && !s.wait_req;
    wr_acc  = avs_write_i && !s.wait_req;

    n.sync1 = {mode_select_high_i, mode_select_low_i};  // see RL18
    n.sync2 = s.sync1;                                  // see RL18

    // Buffer fill; ready is low during init so no byte is lost
    if (host_byte_valid_i && s.host_ready) begin
      push   = 1'b1;
      n.idle = 16'h0000;
    end else if (s.idle < s.timeout) begin
      n.idle = s.idle + 1'b1;
    end
    if (host_byte_valid_i && !s.host_ready && s.state == ST_RUN) begin
      ev[`RMSG_IRQ_OVF] = 1'b1;
    end

    // Sub-packet drain toward the radio chip
    // A timeout written below the running idle count still fires
    if (!s.drain && s.count != '0 &&
        (s.count >= `RMSG_CNT_W'(s.sublen) || s.idle >= s.timeout)) begin  // see RL6
      n.drain   = 1'b1;
      n.sub_cnt = 8'h00;
    end
    if (s.drain && (!s.radio_valid || radio_ready_i)) begin
      if (s.count != '0 && s.sub_cnt != s.sublen) begin
        pop           = 1'b1;
        n.radio_valid = 1'b1;
        n.radio_byte  = mem[s.rd_ptr];
        n.sub_cnt     = s.sub_cnt + 1'b1;
        n.radio_last  = (s.sub_cnt + 1'b1 == s.sublen) || (s.count == 1 && !push);  // see RL6
      end else begin
        n.radio_valid = 1'b0;
        n.radio_last  = 1'b0;
        n.drain       = 1'b0;
      end
    end else if (s.radio_valid && radio_ready_i) begin
      n.radio_valid = 1'b0;
      n.radio_last  = 1'b0;
    end

    if (push) begin
      n.wr_ptr = ptr_inc(s.wr_ptr);
    end
    if (pop) begin
      n.rd_ptr = ptr_inc(s.rd_ptr);
    end
    n.count = s.count + push - pop;

    // Init and mode gate
    case (s.state)
      ST_INIT: begin
        if (s.init_cnt == 8'(INIT_CYCLES - 1)) begin
          n.state    = ST_RUN;                     // see RL2
          n.selected = rmsg_mode_e'(s.sync2);      // see RL2
          n.working  = rmsg_mode_e'(s.sync2);
        end else begin
          n.init_cnt = s.init_cnt + 1'b1;
        end
      end
      ST_RUN: begin
        // Pins are looked at only while the status is high
        // The 1 ms bound is met in three cycles from the pins, so no timer is spent on it
        if (s.aux && s.sync2 != s.selected) begin  // see RL10, RL17
          n.selected = rmsg_mode_e'(s.sync2);
          if (s.selected == MD_SLEEP) begin         // see RL12
            n.state    = ST_INIT;
            n.init_cnt = 8'h00;
          end
        end
        // A switch made early waits until the status has been high long enough
        if (s.working != s.selected && s.hold == HOLD_MAX) begin  // see RL11
          n.working           = s.selected;
          ev[`RMSG_IRQ_MODE]  = 1'b1;
        end
      end
      default: begin
        n.state = ST_INIT;
      end
    endcase

    // Reset pin or software reload restarts the parameter load
    if (!module_reset_input_n_i ||
        (wr_acc && avs_address_i == `RMSG_IDX_CTRL &&
         avs_byteenable_i[0] && avs_writedata_i[`RMSG_CTRL_RELOAD])) begin  // see RL12
      n.state       = ST_INIT;
      n.init_cnt    = 8'h00;
      n.count       = '0;
      n.wr_ptr      = '0;
      n.rd_ptr      = '0;
      n.drain       = 1'b0;
      n.radio_valid = 1'b0;
      n.radio_last  = 1'b0;
      push          = 1'b0;
    end

    // Status: low on any busy condition; rises only with the buffer empty and no radio byte held
    // Low for the first run cycle too, so init never shows as ready
    n.aux = s.state == ST_RUN && n.state == ST_RUN && n.count == '0 &&
            !n.radio_valid && !rx_serial_busy_i;   // see RL1, RL4, RL7, RL8, RL9
    if (!s.aux) begin
      n.hold = '0;
    end else if (s.hold != HOLD_MAX) begin
      n.hold = s.hold + 1'b1;
    end
    if (n.aux && !s.aux) begin
      ev[`RMSG_IRQ_READY] = 1'b1;
    end
    n.host_ready = n.state == ST_RUN && n.count < CNT_MAX;  // see RL5

    // Address filter
    n.rx_accept = rx_frame_valid_i &&
                  (s.own_addr == `RMSG_BCAST_ADDR || rx_dest_addr_i == s.own_addr);  // see RL14

    // Register slave: one wait cycle, then a single answer cycle
    n.wait_req = !((avs_read_i || avs_write_i) && s.wait_req);
    case (avs_address_i)
      `RMSG_IDX_STATUS:  rd_mux = {16'h0000, s.count, s.working,
                                  s.selected, s.state == ST_INIT, s.aux};
      `RMSG_IDX_OWNADDR: rd_mux = {16'h0000, s.own_addr};
      `RMSG_IDX_TIMEOUT: rd_mux = {16'h0000, s.timeout};
      `RMSG_IDX_SUBLEN:  rd_mux = {24'h000000, s.sublen};
      `RMSG_IDX_IRQSTAT: rd_mux = {29'h0, s.irq_stat};
      `RMSG_IDX_IRQMASK: rd_mux = {29'h0, s.irq_mask};
      default:           rd_mux = 32'h0000_0000;
    endcase
    if (avs_read_i && s.wait_req) begin
      n.rdata = rd_mux;
    end
    wmerged = be_merge(rd_mux, avs_writedata_i, avs_byteenable_i);
    if (wr_acc) begin
      case (avs_address_i)
        `RMSG_IDX_OWNADDR: n.own_addr = wmerged[15:0];
        `RMSG_IDX_TIMEOUT: n.timeout  = wmerged[15:0];
        `RMSG_IDX_SUBLEN:  n.sublen   = (wmerged[7:0] == 8'h00) ? 8'h01 : wmerged[7:0];
        `RMSG_IDX_IRQMASK: n.irq_mask = wmerged[`RMSG_IRQ_W-1:0];
        default:           n.irq_mask = s.irq_mask;
      endcase
    end
    // Set wins over a write-one clear in the same cycle
    n.irq_stat = s.irq_stat | ev;
    if (wr_acc && avs_address_i == `RMSG_IDX_IRQSTAT && avs_byteenable_i[0]) begin
      n.irq_stat = (s.irq_stat & ~avs_writedata_i[`RMSG_IRQ_W-1:0]) | ev;
    end
    n.irq       = |(n.irq_stat & n.irq_mask);
    n.broadcast = n.own_addr == `RMSG_BCAST_ADDR;  // see RL13
    if (acc) begin
      n.wait_req = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // State and buffer storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s          <= '0;
      s.state    <= ST_INIT;                       // see RL1
      s.wait_req <= 1'b1;
      s.own_addr <= `RMSG_RST_OWNADDR;
      s.timeout  <= `RMSG_RST_TIMEOUT;
      s.sublen   <= `RMSG_RST_SUBLEN;
    end else begin
      s <= n;
    end
  end

  // Storage has no reset; occupancy alone says what is valid
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[s.wr_ptr] <= host_byte_i;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign aux_o             = s.aux;
  assign host_ready_o      = s.host_ready;
  assign radio_valid_o     = s.radio_valid;
  assign radio_byte_o      = s.radio_byte;
  assign radio_last_o      = s.radio_last;
  assign rx_accept_o       = s.rx_accept;
  assign tx_broadcast_o    = s.broadcast;
  assign working_mode_o    = s.working;
  assign avs_readdata_o    = s.rdata;
  assign avs_waitrequest_o = s.wait_req;
  assign irq_o             = s.irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  AST_INIT_LOW: assert property (s.state == ST_INIT |=> !s.aux)  // see RL1
    else $error("status high during init");
  AST_RISE_RUN: assert property ($rose(s.state == ST_RUN) |->  // see RL2
                                 s.working == $past(s.sync2) && !s.aux)
    else $error("run entered without pin mode");
  AST_BUF_BUSY: assert property (s.count != '0 || (s.radio_valid && !radio_ready_i)  // see RL4
                                 |=> !s.aux)
    else $error("status high with buffered data");
  AST_NO_OVF: assert property (s.count <= CNT_MAX &&  // see RL5
                               (!s.host_ready || s.count < CNT_MAX))
    else $error("buffer overflow");
  AST_SUBPKT: assert property (s.drain |-> s.sub_cnt <= s.sublen)  // see RL6
    else $error("sub-packet too long");
  AST_RX_BUSY: assert property (rx_serial_busy_i |=> !s.aux)  // see RL8
    else $error("status high while serial output pending");
  AST_AUX_ALL: assert property (s.aux |->  // see RL9
                                s.count == '0 && !s.radio_valid && s.state == ST_RUN)
    else $error("status high while busy");
  AST_NO_EVAL: assert property (s.state == ST_RUN && !s.aux && module_reset_input_n_i  // see RL10
                                |=> $stable(s.selected))
    else $error("pins evaluated while status low");
  AST_SWITCH: assert property (s.state == ST_RUN && s.aux && s.sync2 != s.selected  // see RL10
                               && module_reset_input_n_i |=> s.selected == $past(s.sync2))
    else $error("mode switch not taken");
  AST_HOLD: assert property (s.state == ST_RUN && $past(s.state) == ST_RUN  // see RL11
                             && $changed(s.working) |-> $past(s.hold) == HOLD_MAX)
    else $error("mode active before hold time");
  AST_WAKE: assert property (s.state == ST_RUN && s.aux && s.selected == MD_SLEEP  // see RL12
                             && s.sync2 != MD_SLEEP |=> s.state == ST_INIT)
    else $error("no reload after sleep");
  AST_LISTEN: assert property (rx_frame_valid_i && s.own_addr == `RMSG_BCAST_ADDR  // see RL14
                               |=> s.rx_accept)
    else $error("listen address dropped frame");

  // Antecedents use the registered state or the event vector ev; inputs only where a rule names them
  AST_FILTER: assert property (rx_frame_valid_i && s.own_addr != `RMSG_BCAST_ADDR  // see RL14
                               && rx_dest_addr_i != s.own_addr |=> !s.rx_accept)
    else $error("foreign frame accepted");
  AST_BCAST: assert property (s.broadcast == (s.own_addr == `RMSG_BCAST_ADDR))  // see RL13
    else $error("broadcast flag out of step");
  AST_RELOAD: assert property (!module_reset_input_n_i |=>  // see RL12
                               s.state == ST_INIT && !s.aux)
    else $error("reset pin did not restart init");
  AST_SYNC: assert property ($changed(s.selected) |-> s.selected == $past(s.sync2))  // see RL18
    else $error("mode taken before second stage");
  AST_HOST_INIT: assert property (s.state != ST_RUN |-> !s.host_ready)  // see RL12
    else $error("host bytes taken during reload");
  AST_IRQ_SET: assert property (ev != '0 |=> (s.irq_stat & $past(ev)) == $past(ev))  // see RL3
    else $error("event lost against clear");

  // ---------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------
  COV_READY: cover property (s.state == ST_INIT ##1 s.state == ST_RUN ##1 s.aux);
  COV_WAKE: cover property (s.working == MD_SLEEP && s.state == ST_INIT);
  COV_SWITCH: cover property (s.aux && s.sync2 != s.selected ##1 s.working != s.selected);
  COV_DRAIN: cover property (s.radio_valid && radio_ready_i && s.radio_last);
  COV_BCAST: cover property (s.broadcast && s.rx_accept);

endmodule

// ===== tb/rmsg_host_model.sv
// Host microcontroller model: mode pins and byte stream
`timescale 1ns/1ps
module rmsg_host_model (
  // Clock and ready
  input  wire logic       clk_sys_i,
  input  wire logic       host_ready_i,
  // Driven pins
  output logic            host_byte_valid_o,
  output logic [7:0]      host_byte_o,
  output logic            mode_select_low_o,
  output logic            mode_select_high_o
);
  // Bytes whose wait for ready ran out
  int n_stall = 0;
  // Pins driven from time zero, never left floating
  initial begin
    host_byte_valid_o = 1'b0;
    host_byte_o = 8'h00;
    mode_select_low_o = 1'b0;
    mode_select_high_o = 1'b0;
  end
  // Both pins move on the same edge
  task automatic set_mode(input logic [1:0] m);
    mode_select_high_o <= m[1];
    mode_select_low_o  <= m[0];
  endtask
  // Each byte held until taken or 5000 cycles pass; stream stays under the buffer size
  task automatic send(input int n, input logic [7:0] first);
    int k;
    int w;
    for (k = 0; k < n; k++) begin
      host_byte_valid_o <= 1'b1;
      host_byte_o       <= first + k[7:0];
      @(posedge clk_sys_i);
      for (w = 0; w < 5000 && host_ready_i !== 1'b1; w++) @(posedge clk_sys_i);
      if (w == 5000) n_stall++;
    end
    host_byte_valid_o <= 1'b0;
    // Released line shows the inverse, not a stale byte
    host_byte_o       <= ~(first + n[7:0] - 8'h01);
  endtask
endmodule

// ===== tb/tb_rmsg_top.sv
// Self-checking bench for the status output and mode gate
`timescale 1ns/1ps
`include "rmsg_regs.svh"
module tb_rmsg_top;
  import rmsg_pkg::*;
  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  localparam int HOLD = 50;
  localparam int INIT = `RMSG_INIT_CYCLES;
  logic        clk_sys_i = 1'b0;
  logic        reset_i, module_reset_input_n_i, mode_lo, mode_hi, aux_o;
  logic        host_byte_valid_i, host_ready_o, radio_valid_o, radio_last_o;
  logic [7:0]  host_byte_i, radio_byte_o;
  logic        radio_ready_i, rx_frame_valid_i, rx_serial_busy_i, rx_accept_o;
  logic [15:0] rx_dest_addr_i;
  logic        tx_broadcast_o, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
  logic [1:0]  working_mode_o;
  logic [2:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [3:0]  avs_byteenable_i;
  logic [67:0] row;
  int          failures = 0;
  int          n_tests = 0;
  int          n, i;
  // Rows: write flag, index, write data, expected read
  localparam logic [67:0] ROWS [10] = '{
    {1'b0, `RMSG_IDX_STATUS, 32'h0, 32'h29},
    {1'b0, `RMSG_IDX_OWNADDR, 32'h0, 32'h0},
    {1'b0, `RMSG_IDX_TIMEOUT, 32'h0, 32'h100},
    {1'b0, `RMSG_IDX_SUBLEN, 32'h0, 32'hf0},
    {1'b0, `RMSG_IDX_IRQMASK, 32'h0, 32'h0},
    {1'b0, `RMSG_IDX_CTRL, 32'h0, 32'h0},
    {1'b1, 3'h7, 32'hffffffff, 32'h0},
    {1'b1, `RMSG_IDX_SUBLEN, 32'h0, 32'h1},
    {1'b1, `RMSG_IDX_SUBLEN, 32'hf0, 32'hf0},
    {1'b1, `RMSG_IDX_OWNADDR, 32'hffff, 32'hffff}};

  always #2.5 clk_sys_i = ~clk_sys_i;

  rmsg_top #(.HOLD_CYCLES(HOLD)) u_dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .module_reset_input_n_i(module_reset_input_n_i),
    .mode_select_low_i(mode_lo), .mode_select_high_i(mode_hi), .aux_o(aux_o),
    .host_byte_valid_i(host_byte_valid_i), .host_byte_i(host_byte_i),
    .host_ready_o(host_ready_o), .radio_valid_o(radio_valid_o),
    .radio_byte_o(radio_byte_o), .radio_last_o(radio_last_o),
    .radio_ready_i(radio_ready_i), .rx_frame_valid_i(rx_frame_valid_i),
    .rx_dest_addr_i(rx_dest_addr_i), .rx_serial_busy_i(rx_serial_busy_i),
    .rx_accept_o(rx_accept_o), .tx_broadcast_o(tx_broadcast_o),
    .working_mode_o(working_mode_o), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .irq_o(irq_o));

  rmsg_host_model u_host (
    .clk_sys_i(clk_sys_i), .host_ready_i(host_ready_o),
    .host_byte_valid_o(host_byte_valid_i), .host_byte_o(host_byte_i),
    .mode_select_low_o(mode_lo), .mode_select_high_o(mode_hi));

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [1:0] cur(input int w);
    case (w)
      0: return {1'b0, aux_o};
      1: return working_mode_o;
      default: return {1'b0, radio_valid_o};
    endcase
  endfunction

  // Bounded wait for a level; running out ends the run
  task automatic wait_for(input int w, input logic [1:0] v, input int max, output int c);
    for (c = 0; c < max; c++) begin
      @(posedge clk_sys_i);
      if (cur(w) === v) return;
    end
    failures++;
    stop_test();
  endtask

  // Request held until waitrequest is seen low at an edge
  task automatic acc(input logic wr, input logic [2:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    int k;
    avs_address_i    <= a;
    avs_write_i      <= wr;
    avs_read_i       <= !wr;
    avs_writedata_i  <= wd;
    avs_byteenable_i <= 4'hf;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    if (k == 50) begin
      failures++;
      stop_test();
    end
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic rx(input logic [15:0] d, input logic exp);
    rx_frame_valid_i <= 1'b1;
    rx_dest_addr_i   <= d;
    @(posedge clk_sys_i);
    rx_frame_valid_i <= 1'b0;
    rx_dest_addr_i   <= ~d;
    @(posedge clk_sys_i);
    chk(32'(rx_accept_o), 32'(exp));
  endtask

  // ----------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    failures++;
    stop_test();
  end

  initial begin
    reset_i = 1'b1;
    module_reset_input_n_i = 1'b1;
    radio_ready_i = 1'b0;
    rx_frame_valid_i = 1'b0;
    rx_dest_addr_i = 16'h0000;
    rx_serial_busy_i = 1'b0;
    avs_address_i = 3'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    u_host.set_mode(2'h2);
    repeat (5) @(posedge clk_sys_i);
    chk(32'(aux_o), 32'h0);
    chk(32'(avs_waitrequest_o), 32'h1);
    reset_i <= 1'b0;
    // Host treats the first status rise as the start of operation
    wait_for(0, 2'h1, 300, n);
    chk(32'(n >= INIT - 2), 32'h1);
    chk(32'(working_mode_o), 32'h2);
    $display("reset test done");
    for (i = 0; i < 10; i++) begin
      row = ROWS[i];
      if (row[67]) acc(1'b1, row[66:64], row[63:32], rd);
      acc(1'b0, row[66:64], 32'h0, rd);
      chk(rd, row[31:0]);
    end
    $display("register test done");
    chk(32'(tx_broadcast_o), 32'h1);
    rx(16'h1234, 1'b1);
    acc(1'b1, `RMSG_IDX_OWNADDR, 32'h0055, rd);
    chk(32'(tx_broadcast_o), 32'h0);
    rx(16'h1234, 1'b0);
    rx(16'h0055, 1'b1);
    $display("address test done");
    for (i = 0; i < 4; i++) begin
      u_host.set_mode(i[1:0]);
      wait_for(1, i[1:0], 10, n);
      chk(32'(working_mode_o), 32'(i));
    end
    // Leaving deep sleep reloads parameters with the status low
    u_host.set_mode(2'h0);
    wait_for(0, 2'h0, 10, n);
    wait_for(0, 2'h1, 300, n);
    chk(32'(n >= INIT - 4), 32'h1);
    module_reset_input_n_i <= 1'b0;
    wait_for(0, 2'h0, 10, n);
    module_reset_input_n_i <= 1'b1;
    wait_for(0, 2'h1, 300, n);
    chk(32'(n >= INIT - 4), 32'h1);
    $display("mode test done");
    acc(1'b1, `RMSG_IDX_IRQSTAT, 32'h7, rd);
    acc(1'b1, `RMSG_IDX_IRQMASK, 32'h2, rd);
    rx_serial_busy_i <= 1'b1;
    wait_for(0, 2'h0, 10, n);
    u_host.set_mode(2'h1);
    repeat (20) @(posedge clk_sys_i);
    chk(32'(working_mode_o), 32'h0);
    rx_serial_busy_i <= 1'b0;
    wait_for(0, 2'h1, 10, n);
    wait_for(1, 2'h1, HOLD + 20, n);
    chk(32'(n >= HOLD - 4), 32'h1);
    repeat (3) @(posedge clk_sys_i);
    chk(32'(irq_o), 32'h1);
    acc(1'b1, `RMSG_IDX_IRQSTAT, 32'h2, rd);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(irq_o), 32'h0);
    $display("gate test done");
    acc(1'b1, `RMSG_IDX_TIMEOUT, 32'h20, rd);
    u_host.send(5, 8'h40);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(aux_o), 32'h0);
    wait_for(2, 2'h1, 200, n);
    chk(32'(aux_o), 32'h0);
    radio_ready_i <= 1'b1;
    for (i = 0; i < 5; i++) begin
      wait_for(2, 2'h1, 20, n);
      chk({radio_last_o, radio_byte_o}, {23'h0, i == 4, 8'h40 + i[7:0]});
    end
    wait_for(0, 2'h1, 20, n);
    $display("transmit test done");
    // Radio stalls while the host streams just under the buffer size
    acc(1'b1, `RMSG_IDX_IRQSTAT, 32'h1, rd);
    radio_ready_i <= 1'b0;
    u_host.send(999, 8'h00);
    chk(32'(host_ready_o), 32'h1);
    acc(1'b0, `RMSG_IDX_IRQSTAT, 32'h0, rd);
    chk(rd & 32'h4, 32'h0);
    radio_ready_i <= 1'b1;
    wait_for(0, 2'h1, 5000, n);
    acc(1'b0, `RMSG_IDX_IRQSTAT, 32'h0, rd);
    chk(rd & 32'h1, 32'h1);
    chk(32'(u_host.n_stall), 32'h0);
    $display("stream test done");
    stop_test();
  end
endmodule
